// ==== common/ssg_pkg.sv ====
// Constants, register map and carriers for the sample sync generator.
// Assumes a 200 MHz pclk and an APB master with 32-bit data.
package ssg_pkg;

  localparam int unsigned CLK_MHZ            = 200;
  // Times in their own units, cycle counts derived from them
  localparam int unsigned TURN_ON_DELAY_NS   = 20000;
  localparam int unsigned SETTLING_TIME_NS   = 40000;
  localparam int unsigned CLK_FAIL_PERIOD_US = 6500;
  localparam int unsigned FULL_DUTY_PULSE_NS = 100000;
  localparam int unsigned BLANK_CYC          = ((TURN_ON_DELAY_NS + SETTLING_TIME_NS) * CLK_MHZ + 999) / 1000;
  localparam int unsigned CLK_FAIL_HALF_CYC  = (CLK_FAIL_PERIOD_US * CLK_MHZ) / 2;
  localparam int unsigned FULL_DUTY_CYC      = (FULL_DUTY_PULSE_NS * CLK_MHZ) / 1000;
  localparam int unsigned VOLT_DIV           = 1024;
  localparam int unsigned VOLT_HALF_TICKS    = VOLT_DIV / 2;
  localparam int unsigned TMR_W              = 24;

  localparam int unsigned NUM_OUT            = 5;

  // Sync mode encodings {high bit, low bit}
  localparam logic [1:0] SYNC_OFF            = 2'h0;
  localparam logic [1:0] SYNC_VALID          = 2'h1;
  localparam logic [1:0] SYNC_TRIG_CYCLE     = 2'h2;
  localparam logic [1:0] SYNC_MIDPULSE       = 2'h3;

  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFFSET         = 8'h00;
  localparam logic [7:0] STATUS_OFFSET       = 8'h04;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;

  typedef struct packed {
    logic [25:0] reserved;
    logic        offset_averaging_mode;
    logic        sync_mode_high_bit;
    logic        sync_mode_low_bit;
    logic [2:0]  feedback_select;
  } ssg_ctrl_s;

  typedef struct packed {
    logic [26:0] reserved;
    logic        blanking;
    logic        fallback_active;
    logic        offset_polarity;
    logic        drive_low;
    logic        pin_level;
  } ssg_status_s;

endpackage

// ==== hw/ssg_square.sv ====
// Free-running 50 % square wave: toggles after HALF qualifying ticks.
// Assumes tick is a one-cycle pulse on pclk; run low holds it reset.
`timescale 1ns/1ps
module ssg_square
  import ssg_pkg::*;
#(
  parameter int unsigned HALF = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic tick,
  output logic      wave_q
);

  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      wave_q <= 1'b0;
    end else if (!run) begin
      cnt_q  <= '0;
      wave_q <= 1'b0;
    end else if (tick) begin
      if (cnt_q == TMR_W'(HALF - 1)) begin
        cnt_q  <= '0;
        wave_q <= ~wave_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// ==== hw/ssg_top.sv ====
// Sample sync generator: drives the open-drain sample sync pin low when the
// analog feedback pin may be sampled. APB slave holds control and status.
// Assumes all channel inputs come from pclk-domain logic; the pin return
// is asynchronous and is synchronised before use.
`timescale 1ns/1ps
module ssg_top
  import ssg_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES     = BLANK_CYC,
  parameter int unsigned CLK_FAIL_HALF    = CLK_FAIL_HALF_CYC,
  parameter int unsigned FULL_DUTY_CYCLES = FULL_DUTY_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               normal_mode,
  input  wire logic               pwm_clk_fail,
  input  wire logic               pwm_clk_tick,
  input  wire logic               pwm_cycle_start,
  input  wire logic               pwm_overflow,
  input  wire logic [NUM_OUT-1:0] out_ctrl,
  input  wire logic [NUM_OUT-1:0] full_duty,
  input  wire logic [NUM_OUT-1:0] high_overcurrent_window,
  input  wire logic [NUM_OUT-1:0] output_fault,
  input  wire logic [NUM_OUT-1:0] output_enable,
  input  wire logic               sample_sync_pin_i,
  output logic                    sample_sync_pin_o,
  output logic                    sample_sync_pin_oe_n,
  output logic                    offset_polarity_q
);

  ssg_ctrl_s        ctrl_q;
  ssg_status_s      status;
  logic             wr_en;
  logic             rd_hit;
  logic             pin_meta_q;
  logic             pin_sync_q;
  logic             pin_prev_q;
  logic             drive_low_q;
  logic             drive_low_d;
  logic [1:0]       mode;
  logic             is_current;
  logic [2:0]       sel_idx;
  logic             sel_on;
  logic             sel_hoc;
  logic             sel_full;
  logic             sel_fault;
  logic             sel_en_prev;
  logic [NUM_OUT-1:0] fault_q;
  logic [NUM_OUT-1:0] en_prev_q;
  logic             mux_change;
  logic [TMR_W-1:0] blank_q;
  logic             blanking;
  logic             cycle_wait_q;
  logic             mid_wait_q;
  logic [TMR_W-1:0] on_cnt_q;
  logic [TMR_W-1:0] last_len_q;
  logic             on_prev_q;
  logic             at_mid;
  logic [TMR_W-1:0] full_cnt_q;
  logic             fail_wave;
  logic             volt_wave;

  assign mode       = {ctrl_q.sync_mode_high_bit, ctrl_q.sync_mode_low_bit};
  // Selections beyond the last output name voltage feedback
  // type by select
  assign is_current = ctrl_q.feedback_select < 3'(NUM_OUT);
  assign sel_idx    = is_current ? ctrl_q.feedback_select : 3'h0;
  assign sel_on     = out_ctrl[sel_idx];
  assign sel_hoc    = high_overcurrent_window[sel_idx];
  assign sel_full   = full_duty[sel_idx];
  assign sel_fault  = fault_q[sel_idx];
  assign sel_en_prev = en_prev_q[sel_idx];

  // APB slave: zero wait states, unmapped addresses flag an error
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && (paddr == CTRL_OFFSET);
  assign rd_hit  = (paddr == CTRL_OFFSET) || (paddr == STATUS_OFFSET);
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ssg_ctrl_s'(CTRL_RESET);
    end else if (wr_en) begin
      ctrl_q          <= ssg_ctrl_s'(CTRL_RESET);
      ctrl_q.feedback_select       <= pwdata[2:0];
      ctrl_q.sync_mode_low_bit     <= pwdata[3];
      ctrl_q.sync_mode_high_bit    <= pwdata[4];
      ctrl_q.offset_averaging_mode <= pwdata[5];
    end
  end

  always_comb begin
    status                 = '0;
    status.pin_level       = pin_sync_q;
    status.drive_low       = drive_low_q;
    status.offset_polarity = offset_polarity_q;
    status.fallback_active = pwm_clk_fail;
    status.blanking        = blanking;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == CTRL_OFFSET) begin
        prdata <= 32'(ctrl_q);
      end else if (paddr == STATUS_OFFSET) begin
        prdata <= 32'(status);
      end else begin
        prdata <= '0;
      end
    end
  end

  // Pin return is asynchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
      pin_prev_q <= 1'b1;
    end else begin
      pin_meta_q <= sample_sync_pin_i;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_polarity_q <= 1'b0;
    end else if (!ctrl_q.offset_averaging_mode) begin
      offset_polarity_q <= 1'b0;
    end else if (pin_sync_q && !pin_prev_q) begin
      offset_polarity_q <= ~offset_polarity_q;
    end
  end

  // A write that moves the mux or flips averaging restarts settling
  assign mux_change = wr_en &&
    ((pwdata[2:0] != ctrl_q.feedback_select) || (pwdata[5] != ctrl_q.offset_averaging_mode));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_q <= '0;
    end else if (mux_change) begin
      blank_q <= TMR_W'(BLANK_CYCLES);
    end else if (blank_q != '0) begin
      blank_q <= blank_q - 1'b1;
    end
  end
  assign blanking = blank_q != '0;

  // fault latch per output, cleared by re-enable; set wins
  generate
    for (genvar i = 0; i < NUM_OUT; i++) begin : g_fault
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fault_q[i]   <= 1'b0;
          en_prev_q[i] <= 1'b0;
        end else begin
          en_prev_q[i] <= output_enable[i];
          if (output_fault[i]) begin
            fault_q[i] <= 1'b1;
          end else if (output_enable[i] && !en_prev_q[i]) begin
            fault_q[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_wait_q <= 1'b0;
    end else if (mux_change) begin
      cycle_wait_q <= 1'b1;
    end else if (pwm_cycle_start) begin
      cycle_wait_q <= 1'b0;
    end
  end

  // Midpoint taken from the previous pulse length; the first pulse after
  // a switch has no history, so it is skipped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_cnt_q   <= '0;
      last_len_q <= '0;
      on_prev_q  <= 1'b0;
    end else begin
      on_prev_q <= sel_on;
      if (sel_on) begin
        on_cnt_q <= on_cnt_q + 1'b1;
      end else begin
        on_cnt_q <= '0;
      end
      if (mux_change) begin
        last_len_q <= '0;
      end else if (on_prev_q && !sel_on) begin
        last_len_q <= on_cnt_q;
      end
    end
  end
  assign at_mid = sel_on && (last_len_q != '0) && (on_cnt_q >= (last_len_q >> 1));

  // blank from switch to next midpoint
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mid_wait_q <= 1'b0;
    end else if (mux_change) begin
      mid_wait_q <= 1'b1;
    end else if (at_mid && !blanking) begin
      mid_wait_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_cnt_q <= '0;
    end else if (pwm_overflow && sel_full) begin
      full_cnt_q <= TMR_W'(FULL_DUTY_CYCLES);
    end else if (full_cnt_q != '0) begin
      full_cnt_q <= full_cnt_q - 1'b1;
    end
  end

  ssg_square #(
    .HALF (CLK_FAIL_HALF)
  ) u_fail_wave (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (pwm_clk_fail),
    .tick    (1'b1),
    .wave_q  (fail_wave)
  );

  ssg_square #(
    .HALF (VOLT_HALF_TICKS)
  ) u_volt_wave (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (!is_current),
    .tick    (pwm_clk_tick),
    .wave_q  (volt_wave)
  );

  always_comb begin
    drive_low_d = 1'b0;
    if (!normal_mode) begin
      drive_low_d = 1'b0;
    end else if (pwm_clk_fail) begin
      drive_low_d = fail_wave;
    end else if (!is_current) begin
      drive_low_d = volt_wave;
    end else if (sel_fault || sel_hoc || blanking) begin
      drive_low_d = 1'b0;
    end else if (sel_full && (mode == SYNC_TRIG_CYCLE || mode == SYNC_MIDPULSE)) begin
      drive_low_d = (full_cnt_q == '0);
    end else begin
      // per sync mode: off, recopy of control, on phase after cycle start, or midpulse
      case (mode)
        SYNC_OFF:        drive_low_d = 1'b0;
        SYNC_VALID:      drive_low_d = sel_on;
        SYNC_TRIG_CYCLE: drive_low_d = sel_on && !cycle_wait_q;
        SYNC_MIDPULSE:   drive_low_d = at_mid && !mid_wait_q;
        default:         drive_low_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_low_q <= 1'b0;
    end else begin
      drive_low_q <= drive_low_d;
    end
  end

  // open drain, only ever pulls low
  assign sample_sync_pin_o    = 1'b0;
  assign sample_sync_pin_oe_n = ~drive_low_q;

endmodule

// ==== sim/ssg_checker.sv ====
// Checker for the sample sync pin of ssg_top.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/1ps
module ssg_checker
  import ssg_pkg::*;
(
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               normal_mode,
  input wire logic               pwm_clk_fail,
  input wire logic               pwm_clk_tick,
  input wire logic [NUM_OUT-1:0] out_ctrl,
  input wire logic [NUM_OUT-1:0] full_duty,
  input wire logic [NUM_OUT-1:0] high_overcurrent_window,
  input wire logic [NUM_OUT-1:0] output_fault,
  input wire logic [NUM_OUT-1:0] output_enable,
  input wire logic               sample_sync_pin_o,
  input wire logic               sample_sync_pin_oe_n,
  input wire logic               offset_polarity_q
);
  logic [5:0] ctl_q;
  logic [4:0] flt_q;
  logic [4:0] en_q;
  logic [2:0] sel;
  logic       run;
  logic       cur;
  logic       vs;
  assign sel = ctl_q[2:0];
  assign run = normal_mode && !pwm_clk_fail;
  assign cur = run && sel < 3'h5;
  assign vs  = run && sel >= 3'h5;
  // Shadow of the control word, taken at the write's access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 6'h00;
    end else if (psel && penable && pwrite && paddr == CTRL_OFFSET) begin
      ctl_q <= pwdata[5:0];
    end
  end
  // Fault latch; a new fault beats a re-enable in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_q <= 5'h00;
      en_q  <= 5'h00;
    end else begin
      flt_q <= (flt_q & ~(output_enable & ~en_q)) | output_fault;
      en_q  <= output_enable;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pin_zero_a: assert property (sample_sync_pin_o == 1'b0)
    else $error("sync pin data not low");
  not_normal_a: assert property (!normal_mode |=> sample_sync_pin_oe_n)
    else $error("sync pin driven outside normal mode");
  mode_off_a: assert property (cur && ctl_q[4:3] == SYNC_OFF |=> sample_sync_pin_oe_n)
    else $error("sync pin driven in off setting");
  overcurrent_a: assert property (cur && high_overcurrent_window[sel] |=> sample_sync_pin_oe_n)
    else $error("sync pin driven in overcurrent window");
  off_phase_a: assert property (cur && !out_ctrl[sel] && !full_duty[sel] |=> sample_sync_pin_oe_n)
    else $error("sync pin driven in off phase");
  fault_hold_a: assert property (cur && flt_q[sel] |=> sample_sync_pin_oe_n)
    else $error("sync pin driven after output fault");
  volt_steady_a: assert property (vs && !pwm_clk_tick ##1 vs |=> $stable(sample_sync_pin_oe_n))
    else $error("voltage square moved without a tick");
  avg_off_a: assert property (!ctl_q[5] |=> !offset_polarity_q)
    else $error("offset polarity set with averaging off");
  apb_err_a: assert property (psel && penable && paddr != CTRL_OFFSET && paddr != STATUS_OFFSET |-> pslverr && pready)
    else $error("unmapped access not flagged");
endmodule
bind ssg_top ssg_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .normal_mode, .pwm_clk_fail, .pwm_clk_tick, .out_ctrl, .full_duty, .high_overcurrent_window, .output_fault,
  .output_enable, .sample_sync_pin_o, .sample_sync_pin_oe_n, .offset_polarity_q);

// ==== sim/ssg_mcu_model.sv ====
// Host side of the sample sync pin: board pull-up and converter starts.
// Assumes the pin is released through an active-low enable.
`timescale 1ns/1ps
module ssg_mcu_model (
  input  wire logic oe_n,
  input  wire logic pin_o,
  output logic      level,
  output logic [15:0] samples
);
  assign level = oe_n ? 1'b1 : pin_o;
  initial samples = 16'h0000;
  // A falling edge starts one conversion
  always @(negedge level) samples <= samples + 16'h0001;
endmodule

// ==== sim/tb_ssg_top.sv ====
// Bench for ssg_top: APB accesses plus channel stimulus.
// Host model resolves the open-drain pin and feeds it back.
`timescale 1ns/1ps
module tb_ssg_top
  import ssg_pkg::*;
;
  localparam int BLK = 10, CFH = 8, FDC = 5;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, err, pol, tick_en = 1'b0;
  logic        normal_mode = 1'b0, pwm_clk_fail = 1'b0, pwm_clk_tick = 1'b0;
  logic        pwm_cycle_start = 1'b0, pwm_overflow = 1'b0;
  logic [4:0]  out_ctrl = 5'h00, full_duty = 5'h00, high_overcurrent_window = 5'h00;
  logic [4:0]  output_fault = 5'h00, output_enable = 5'h1f;
  logic        sample_sync_pin_i, sample_sync_pin_o, sample_sync_pin_oe_n, offset_polarity_q;
  int          checked = 0, failures = 0;

  ssg_top #(.BLANK_CYCLES(BLK), .CLK_FAIL_HALF(CFH), .FULL_DUTY_CYCLES(FDC)) dut (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .normal_mode, .pwm_clk_fail,
    .pwm_clk_tick, .pwm_cycle_start, .pwm_overflow, .out_ctrl, .full_duty, .high_overcurrent_window,
    .output_fault, .output_enable, .sample_sync_pin_i, .sample_sync_pin_o, .sample_sync_pin_oe_n,
    .offset_polarity_q);
  ssg_mcu_model mcu (.oe_n(sample_sync_pin_oe_n), .pin_o(sample_sync_pin_o), .level(sample_sync_pin_i),
    .samples());

  always #2.5 pclk = ~pclk;
  // PWM clock tick on every other cycle
  always @(posedge pclk) pwm_clk_tick <= tick_en & ~pwm_clk_tick;

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input int n, input logic e);
    cyc(n);
    chk(sample_sync_pin_i, e);
  endtask
  // One idle cycle after release keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    cyc(1);
    penable <= 1'b1;
    do begin
      cyc(1);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      failures++;
    cyc(1);
  endtask
  task automatic phase(input int exp, input int k);
    int n;
    logic l;
    n = 0;
    l = sample_sync_pin_i;
    while (sample_sync_pin_i === l && n < 3000) begin
      cyc(1);
      n++;
    end
    repeat (k) begin
      l = sample_sync_pin_i;
      n = 0;
      while (sample_sync_pin_i === l && n < 3000) begin
        cyc(1);
        n++;
      end
      chk(n, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    cyc(16);
    presetn <= 1'b1;
    normal_mode <= 1'b1;
    cyc(2);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk(rdat, CTRL_RESET);
    apb(1'b1, STATUS_OFFSET, 32'hffff_ffff);
    chk(err, 1'b0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk(rdat[1:0], 2'h1);
    apb(1'b1, 8'h08, 32'h3f);
    apb(1'b0, 8'h08, 32'h0);
    chk(rdat, 32'h0);
    chk(err, 1'b1);
    done("registers");
    out_ctrl <= 5'h01;
    // Move the mux away and back so the second write restarts settling
    apb(1'b1, CTRL_OFFSET, 32'h01);
    apb(1'b1, CTRL_OFFSET, 32'h08);
    pin(3, 1'b1);
    pin(BLK + 2, 1'b0);
    out_ctrl <= 5'h00;
    pin(3, 1'b1);
    out_ctrl <= 5'h01;
    pin(3, 1'b0);
    high_overcurrent_window <= 5'h01;
    pin(3, 1'b1);
    high_overcurrent_window <= 5'h00;
    pin(3, 1'b0);
    output_fault <= 5'h01;
    cyc(1);
    output_fault <= 5'h00;
    pin(3, 1'b1);
    output_enable <= 5'h1e;
    cyc(2);
    output_enable <= 5'h1f;
    pin(3, 1'b0);
    done("valid and suppression");
    apb(1'b1, CTRL_OFFSET, 32'h28);
    cyc(BLK + 4);
    pol = offset_polarity_q;
    for (int i = 1; i < 4; i++) begin
      out_ctrl <= 5'h00;
      cyc(6);
      chk(offset_polarity_q, pol ^ i[0]);
      out_ctrl <= 5'h01;
      cyc(4);
    end
    apb(1'b1, CTRL_OFFSET, 32'h01);
    out_ctrl <= 5'h02;
    cyc(1);
    chk(offset_polarity_q, 1'b0);
    pin(BLK + 4, 1'b1);
    done("averaging and off");
    out_ctrl <= 5'h01;
    apb(1'b1, CTRL_OFFSET, 32'h10);
    pin(BLK + 4, 1'b1);
    pwm_cycle_start <= 1'b1;
    cyc(1);
    pwm_cycle_start <= 1'b0;
    pin(3, 1'b0);
    full_duty <= 5'h01;
    pin(3, 1'b0);
    pwm_overflow <= 1'b1;
    cyc(1);
    pwm_overflow <= 1'b0;
    pin(2, 1'b1);
    pin(FDC + 2, 1'b0);
    full_duty <= 5'h00;
    out_ctrl <= 5'h00;
    apb(1'b1, CTRL_OFFSET, 32'h18);
    cyc(BLK + 4);
    for (int i = 0; i < 2; i++) begin
      out_ctrl <= 5'h01;
      pin(2, 1'b1);
      pin(5, i == 0);
      out_ctrl <= 5'h00;
      pin(3, 1'b1);
    end
    done("trigger modes");
    apb(1'b1, CTRL_OFFSET, 32'h05);
    tick_en <= 1'b1;
    phase(2 * VOLT_HALF_TICKS, 2);
    pwm_clk_fail <= 1'b1;
    phase(CFH, 2);
    apb(1'b1, CTRL_OFFSET, 32'h08);
    phase(CFH, 2);
    pwm_clk_fail <= 1'b0;
    out_ctrl <= 5'h01;
    pin(4, 1'b0);
    normal_mode <= 1'b0;
    pin(3, 1'b1);
    done("squares and mode");
    end_sim();
  end

  initial begin
    cyc(20000);
    failures++;
    end_sim();
  end
endmodule
